// file: pwic_pkg.sv
// Overview of operation
// - 50 ns steps, widths up to 3.27 ms undivided; 3.2 us steps at divide-by-64
// - Selected pin edge copies counter into capture
// - Capture clears counter when selected as source
// - Capture sets flag; enabled flag raises interrupt
// - Control 0x20: clear on capture, undivided clock
// - Pin nibble 0x08 rising; bit0 set falling
// - Enable value 0x41 enables capture interrupt
// - Flag sticks until software writes zero to status or one to clear
// - Counter runs only while start bit set
package pwic_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int PERIPH_PERIOD_NS = 50;
	localparam int PERIPH_DIV_RAW = PERIPH_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PERIPH_DIV_CYCLES = (PERIPH_DIV_RAW < 1) ? 1 : PERIPH_DIV_RAW;
	localparam int CNT_W = 16;
	localparam int DIV_W = 8;
	localparam logic [DIV_W-1:0] PERIPH_DIV_LAST = DIV_W'(PERIPH_DIV_CYCLES - 1);

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [31:0] IDX_CTRL = 32'hffff8260;
	localparam logic [31:0] IDX_PINIO = 32'hffff8262;
	localparam logic [31:0] IDX_IE = 32'hffff8264;
	localparam logic [31:0] IDX_STATUS = 32'hffff8265;
	localparam logic [31:0] IDX_COUNT = 32'hffff8266;
	localparam logic [31:0] IDX_CAPA = 32'hffff8268;
	localparam logic [31:0] IDX_CLEAR = 32'hffff8269;
	localparam logic [31:0] IDX_START = 32'hffff8280;
	localparam logic [ADDR_W-1:0] ADDR_CTRL = ADDR_W'(IDX_CTRL << 2);
	localparam logic [ADDR_W-1:0] ADDR_PINIO = ADDR_W'(IDX_PINIO << 2);
	localparam logic [ADDR_W-1:0] ADDR_IE = ADDR_W'(IDX_IE << 2);
	localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(IDX_STATUS << 2);
	localparam logic [ADDR_W-1:0] ADDR_COUNT = ADDR_W'(IDX_COUNT << 2);
	localparam logic [ADDR_W-1:0] ADDR_CAPA = ADDR_W'(IDX_CAPA << 2);
	localparam logic [ADDR_W-1:0] ADDR_CLEAR = ADDR_W'(IDX_CLEAR << 2);
	localparam logic [ADDR_W-1:0] ADDR_START = ADDR_W'(IDX_START << 2);

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_CLR_LSB = 5;
	localparam logic [2:0] CLR_SRC_CAPA = 3'h1;
	localparam int CTRL_PSC_LSB = 0;
	localparam logic [2:0] PSC_DIV1 = 3'h0;
	localparam logic [2:0] PSC_DIV4 = 3'h1;
	localparam logic [2:0] PSC_DIV16 = 3'h2;
	localparam logic [2:0] PSC_DIV64 = 3'h3;
	localparam int PINIO_CAP_BIT = 3;
	localparam int PINIO_EDGE_LSB = 0;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;
	localparam int FLAG_CAPA_BIT = 0;
	localparam int FLAG_OVF_BIT = 4;
	localparam logic [7:0] FLAG_MASK = 8'h11;
	localparam int START_CH0_BIT = 0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [CNT_W-1:0] RST_CAPA = 16'hffff;
	localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} pwic_apb_req_type;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} pwic_apb_rsp_type;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'b001,
		BUS_ACCESS = 3'b010,
		BUS_RESP = 3'b100
	} pwic_bus_state_type;

endpackage : pwic_pkg

// file: pwic_edge_sync.sv
module pwic_edge_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic pinAsync,
	output logic risePulse,
	output logic fallPulse
);

	logic meta_r;
	logic sync_r;
	logic prev_r;

	// ----------------------------------------------------------------
	// Two-stage synchroniser, then edge detect on the second stage
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= pinAsync;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	assign risePulse = sync_r & ~prev_r;
	assign fallPulse = ~sync_r & prev_r;

endmodule : pwic_edge_sync

// file: pwic_clock_divider.sv
module pwic_clock_divider (
	input wire logic clk,
	input wire logic rst,
	input wire logic [2:0] prescale,
	output logic countTick
);

	logic [pwic_pkg::DIV_W-1:0] periphCnt_r;
	logic [5:0] preCnt_r;
	logic periphEn;
	logic preHit;

	// ----------------------------------------------------------------
	// Peripheral clock rate as a one-cycle enable
	// ----------------------------------------------------------------
	assign periphEn = (periphCnt_r == pwic_pkg::PERIPH_DIV_LAST);

	always_ff @(posedge clk) begin
		if (rst) begin
			periphCnt_r <= '0;
		end else if (periphEn) begin
			periphCnt_r <= '0;
		end else begin
			periphCnt_r <= periphCnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			preCnt_r <= '0;
		end else if (periphEn) begin
			preCnt_r <= preCnt_r + 1'b1;
		end
	end

	// Undivided setting counts every peripheral cycle
	always_comb begin
		unique case (prescale)
			pwic_pkg::PSC_DIV4: preHit = (preCnt_r[1:0] == 2'h3);
			pwic_pkg::PSC_DIV16: preHit = (preCnt_r[3:0] == 4'hf);
			pwic_pkg::PSC_DIV64: preHit = (preCnt_r == 6'h3f);
			default: preHit = 1'b1;
		endcase
	end

	assign countTick = periphEn & preHit;

endmodule : pwic_clock_divider

// file: pwic_capture_top.sv
module pwic_capture_top (
	input wire logic clk,
	input wire logic rst,
	input pwic_pkg::pwic_apb_req_type apbReq,
	output pwic_pkg::pwic_apb_rsp_type apbRsp,
	input wire logic captureInputPin,
	output logic captureAInterrupt
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] channelControl_r;
	logic [7:0] pinIoControlHigh_r;
	logic [7:0] interruptEnable_r;
	logic [7:0] channelStatus_r;
	logic [7:0] sharedStart_r;
	logic [pwic_pkg::CNT_W-1:0] channelCounter_r;
	logic [pwic_pkg::CNT_W-1:0] captureValueA_r;
	pwic_pkg::pwic_bus_state_type busState_r;
	pwic_pkg::pwic_apb_rsp_type apbRsp_r;
	logic irq_r;

	logic risePulse;
	logic fallPulse;
	logic countTick;
	logic captureEvent;
	logic overflowEvent;
	logic counting;
	logic wrEn;
	logic [31:0] rdData;
	logic addrHit;
	logic [7:0] flagSet;
	logic [7:0] flagClr;
	logic [1:0] edgeSel;

	// ----------------------------------------------------------------
	// Pin edges and count rate
	// ----------------------------------------------------------------
	pwic_edge_sync edgeSync (
		.clk(clk),
		.rst(rst),
		.pinAsync(captureInputPin),
		.risePulse(risePulse),
		.fallPulse(fallPulse)
	);

	pwic_clock_divider clockDivider (
		.clk(clk),
		.rst(rst),
		.prescale(channelControl_r[pwic_pkg::CTRL_PSC_LSB +: 3]),
		.countTick(countTick)
	);

	// ----------------------------------------------------------------
	// Capture edge selection
	// ----------------------------------------------------------------
	assign edgeSel = pinIoControlHigh_r[pwic_pkg::PINIO_EDGE_LSB +: 2];

	always_comb begin
		captureEvent = 1'b0;
		if (pinIoControlHigh_r[pwic_pkg::PINIO_CAP_BIT]) begin
			unique case (edgeSel)
				pwic_pkg::EDGE_RISE: captureEvent = risePulse;
				pwic_pkg::EDGE_FALL: captureEvent = fallPulse;
				default: captureEvent = risePulse | fallPulse;
			endcase
		end
	end

	assign counting = sharedStart_r[pwic_pkg::START_CH0_BIT] & countTick;
	assign overflowEvent = counting & (channelCounter_r == '1);

	// ----------------------------------------------------------------
	// APB slave: setup, one wait cycle, then ready
	// ----------------------------------------------------------------
	assign wrEn = (busState_r == pwic_pkg::BUS_RESP) & apbReq.psel & apbReq.penable
		& apbReq.pwrite;

	always_comb begin
		rdData = 32'h0000_0000;
		addrHit = 1'b1;
		unique case (apbReq.paddr)
			pwic_pkg::ADDR_CTRL: rdData[7:0] = channelControl_r;
			pwic_pkg::ADDR_PINIO: rdData[7:0] = pinIoControlHigh_r;
			pwic_pkg::ADDR_IE: rdData[7:0] = interruptEnable_r;
			pwic_pkg::ADDR_STATUS: rdData[7:0] = channelStatus_r;
			pwic_pkg::ADDR_COUNT: rdData[15:0] = channelCounter_r;
			pwic_pkg::ADDR_CAPA: rdData[15:0] = captureValueA_r;
			pwic_pkg::ADDR_CLEAR: rdData = 32'h0000_0000;
			pwic_pkg::ADDR_START: rdData[7:0] = sharedStart_r;
			default: addrHit = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			busState_r <= pwic_pkg::BUS_IDLE;
		end else begin
			unique case (busState_r)
				pwic_pkg::BUS_IDLE: begin
					if (apbReq.psel & ~apbReq.penable) begin
						busState_r <= pwic_pkg::BUS_ACCESS;
					end
				end
				pwic_pkg::BUS_ACCESS: begin
					if (apbReq.psel & apbReq.penable) begin
						busState_r <= pwic_pkg::BUS_RESP;
					end
				end
				pwic_pkg::BUS_RESP: busState_r <= pwic_pkg::BUS_IDLE;
				default: busState_r <= pwic_pkg::BUS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			apbRsp_r <= '0;
		end else if ((busState_r == pwic_pkg::BUS_ACCESS) & apbReq.psel & apbReq.penable) begin
			apbRsp_r.pready <= 1'b1;
			apbRsp_r.pslverr <= ~addrHit;
			apbRsp_r.prdata <= apbReq.pwrite ? 32'h0000_0000 : rdData;
		end else begin
			apbRsp_r <= '0;
		end
	end

	assign apbRsp = apbRsp_r;

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			channelControl_r <= pwic_pkg::RST_BYTE;
			pinIoControlHigh_r <= pwic_pkg::RST_BYTE;
			interruptEnable_r <= pwic_pkg::RST_BYTE;
			sharedStart_r <= pwic_pkg::RST_BYTE;
		end else if (wrEn) begin
			unique case (apbReq.paddr)
				pwic_pkg::ADDR_CTRL: channelControl_r <= apbReq.pwdata[7:0];
				pwic_pkg::ADDR_PINIO: pinIoControlHigh_r <= apbReq.pwdata[7:0];
				pwic_pkg::ADDR_IE: interruptEnable_r <= apbReq.pwdata[7:0];
				pwic_pkg::ADDR_START: sharedStart_r <= apbReq.pwdata[7:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Counter: capture clear beats software write beats count
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			channelCounter_r <= pwic_pkg::RST_COUNT;
		end else if (captureEvent
			& (channelControl_r[pwic_pkg::CTRL_CLR_LSB +: 3] == pwic_pkg::CLR_SRC_CAPA)) begin
			channelCounter_r <= '0;
		end else if (wrEn & (apbReq.paddr == pwic_pkg::ADDR_COUNT)) begin
			channelCounter_r <= apbReq.pwdata[15:0];
		end else if (counting) begin
			channelCounter_r <= channelCounter_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Capture register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			captureValueA_r <= pwic_pkg::RST_CAPA;
		end else if (captureEvent) begin
			captureValueA_r <= channelCounter_r;
		end else if (wrEn & (apbReq.paddr == pwic_pkg::ADDR_CAPA)) begin
			captureValueA_r <= apbReq.pwdata[15:0];
		end
	end

	// ----------------------------------------------------------------
	// Sticky flags: set wins over any clear in the same cycle
	// ----------------------------------------------------------------
	always_comb begin
		flagSet = 8'h00;
		flagSet[pwic_pkg::FLAG_CAPA_BIT] = captureEvent;
		flagSet[pwic_pkg::FLAG_OVF_BIT] = overflowEvent;
		flagClr = 8'h00;
		if (wrEn & (apbReq.paddr == pwic_pkg::ADDR_STATUS)) begin
			flagClr = ~apbReq.pwdata[7:0] & pwic_pkg::FLAG_MASK;
		end else if (wrEn & (apbReq.paddr == pwic_pkg::ADDR_CLEAR)) begin
			flagClr = apbReq.pwdata[7:0] & pwic_pkg::FLAG_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			channelStatus_r <= pwic_pkg::RST_BYTE;
		end else begin
			channelStatus_r <= (channelStatus_r & ~flagClr) | flagSet;
		end
	end

	// ----------------------------------------------------------------
	// Interrupt request
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(channelStatus_r & interruptEnable_r & pwic_pkg::FLAG_MASK);
		end
	end

	assign captureAInterrupt = irq_r;

endmodule : pwic_capture_top

// file: pwic_capture_top_asserts.sv
module pwic_capture_top_asserts (
	input wire logic clk,
	input wire logic rst,
	input pwic_pkg::pwic_apb_req_type apbReq,
	input pwic_pkg::pwic_apb_rsp_type apbRsp,
	input wire logic captureInputPin,
	input wire logic captureAInterrupt
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Port checks
	// ----------------------------------------------------------------
	logic wrDone;
	assign wrDone = apbReq.pwrite && apbRsp.pready;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_readyWait;
		apbReq.psel && !apbReq.penable |-> ##2 apbRsp.pready;
	endproperty
	a_readyWait: assert property (p_readyWait) else $error("late ready");
	property p_readyPulse;
		apbRsp.pready |=> !apbRsp.pready;
	endproperty
	a_readyPulse: assert property (p_readyPulse) else $error("ready too long");
	property p_readyCause;
		apbRsp.pready |-> $past(apbReq.penable) && $past(apbReq.psel);
	endproperty
	a_readyCause: assert property (p_readyCause) else $error("ready no access");
	property p_idle;
		!apbReq.psel |=> !apbRsp.pready;
	endproperty
	a_idle: assert property (p_idle) else $error("ready while idle");
	property p_errReady;
		apbRsp.pslverr |-> apbRsp.pready;
	endproperty
	a_errReady: assert property (p_errReady) else $error("error without ready");
	property p_upperZero;
		apbRsp.pready && !apbReq.pwrite |-> apbRsp.prdata[31:16] == 16'h0000;
	endproperty
	a_upperZero: assert property (p_upperZero) else $error("upper bits set");
	property p_irqFall;
		$fell(captureAInterrupt) |-> $past(wrDone) || $past(wrDone, 2);
	endproperty
	a_irqFall: assert property (p_irqFall) else $error("irq fell alone");
	property p_irqRise;
		$rose(captureAInterrupt) |-> $past(captureInputPin, 2) != $past(captureInputPin, 6)
			|| $past(wrDone) || $past(wrDone, 2);
	endproperty
	a_irqRise: assert property (p_irqRise) else $error("irq without edge");
endmodule : pwic_capture_top_asserts

bind pwic_capture_top pwic_capture_top_asserts u_chk (.clk(clk), .rst(rst), .apbReq(apbReq),
	.apbRsp(apbRsp), .captureInputPin(captureInputPin), .captureAInterrupt(captureAInterrupt));

// file: pwic_pulse_source.sv
module pwic_pulse_source (
	input wire logic clk,
	output logic pinLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// Pulse generator
	// ----------------------------------------------------------------
	initial pinLevel = 1'b0;
	task automatic level(input logic v);
		@(posedge clk);
		pinLevel <= v;
	endtask : level
	task automatic pulse(input int hiCycles, input int loCycles);
		level(1'b1);
		repeat (hiCycles - 1) @(posedge clk);
		level(1'b0);
		repeat (loCycles - 1) @(posedge clk);
		level(1'b1);
	endtask : pulse
endmodule : pwic_pulse_source

// file: pwic_capture_top_tb.sv
module pwic_capture_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic rst;
	pwic_pkg::pwic_apb_req_type req;
	pwic_pkg::pwic_apb_rsp_type rsp;
	logic pin;
	logic irq;
	logic [31:0] rdat;
	logic rerr;
	int errTotal;
	int comparisons;
	pwic_capture_top uut (.clk(clk), .rst(rst), .apbReq(req), .apbRsp(rsp),
		.captureInputPin(pin), .captureAInterrupt(irq));
	pwic_pulse_source src (.clk(clk), .pinLevel(pin));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic results();
		$display("checks %0d errors %0d", comparisons, errTotal);
		if (errTotal == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errTotal++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic near(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		check({31'h0, (v >= lo && v <= hi)}, 32'h1);
	endtask : near
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (rsp.pready !== 1'b1) begin
			errTotal++;
			results();
		end
		rdat = rsp.prdata;
		rerr = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(rdat, exp);
	endtask : rd
	task automatic waitIrq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (irq !== 1'b1) begin
			errTotal++;
			results();
		end
	endtask : waitIrq
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (100000) @(posedge clk);
		errTotal++;
		results();
	end
	initial begin
		rst = 1'b1;
		req = '0;
		errTotal = 0;
		comparisons = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(pwic_pkg::ADDR_CTRL, 32'h0);
		rd(pwic_pkg::ADDR_CAPA, 32'hffff);
		xfer(1'b0, 12'h004, 32'h0);
		check({31'h0, rerr}, 32'h1);
		repeat (30) @(posedge clk);
		rd(pwic_pkg::ADDR_COUNT, 32'h0);
		wr(pwic_pkg::ADDR_CTRL, 32'h20);
		rd(pwic_pkg::ADDR_CTRL, 32'h20);
		wr(pwic_pkg::ADDR_PINIO, 32'h08);
		wr(pwic_pkg::ADDR_IE, 32'h41);
		wr(pwic_pkg::ADDR_START, 32'h1);
		fork
			src.pulse(400, 300);
			begin
				waitIrq();
				rd(pwic_pkg::ADDR_STATUS, 32'h1);
				wr(pwic_pkg::ADDR_STATUS, 32'h0);
				repeat (2) @(posedge clk);
				check({31'h0, irq}, 32'h0);
				wr(pwic_pkg::ADDR_PINIO, 32'h09);
				waitIrq();
				xfer(1'b0, pwic_pkg::ADDR_CAPA, 32'h0);
				near(rdat, 32'd39, 32'd41);
				wr(pwic_pkg::ADDR_STATUS, 32'h0);
				wr(pwic_pkg::ADDR_PINIO, 32'h08);
				waitIrq();
				xfer(1'b0, pwic_pkg::ADDR_CAPA, 32'h0);
				near(rdat, 32'd29, 32'd31);
			end
		join
		wr(pwic_pkg::ADDR_STATUS, 32'h0);
		src.level(1'b0);
		repeat (20) @(posedge clk);
		rd(pwic_pkg::ADDR_STATUS, 32'h0);
		wr(pwic_pkg::ADDR_IE, 32'h0);
		src.level(1'b1);
		repeat (20) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		rd(pwic_pkg::ADDR_STATUS, 32'h1);
		wr(pwic_pkg::ADDR_CLEAR, 32'h1);
		rd(pwic_pkg::ADDR_STATUS, 32'h0);
		wr(pwic_pkg::ADDR_CTRL, 32'h0);
		wr(pwic_pkg::ADDR_COUNT, 32'hfffe);
		repeat (40) @(posedge clk);
		xfer(1'b0, pwic_pkg::ADDR_COUNT, 32'h0);
		near(rdat, 32'd1, 32'd6);
		rd(pwic_pkg::ADDR_STATUS, 32'h10);
		wr(pwic_pkg::ADDR_CTRL, 32'h01);
		wr(pwic_pkg::ADDR_COUNT, 32'h0);
		repeat (80) @(posedge clk);
		xfer(1'b0, pwic_pkg::ADDR_COUNT, 32'h0);
		near(rdat, 32'd1, 32'd3);
		wr(pwic_pkg::ADDR_CLEAR, 32'h11);
		wr(pwic_pkg::ADDR_PINIO, 32'h0a);
		src.level(1'b0);
		repeat (20) @(posedge clk);
		rd(pwic_pkg::ADDR_STATUS, 32'h1);
		results();
	end
endmodule : pwic_capture_top_tb
